/* File: dv/acr_host_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// host audio processor: drives bit clock, word pulse and data
// ----------------------------------------------------------------
module acr_host_model
(
    input wire logic clk,
    input wire logic run,
    output logic bclk,
    output logic wclk,
    output logic din
);
    int ph = 0;
    int bit_n = 31;
    initial
    begin
        bclk = 1'b0;
        wclk = 1'b0;
        din = 1'b0;
    end
    // clocks stand low while run is low; a released data line keeps moving
    // so a stale value is never mistaken for a driven one
    always @(negedge clk)
    begin
        if (!run)
        begin
            bclk <= 1'b0;
            wclk <= 1'b0;
            din <= ~din;
            ph = 0;
            bit_n = 31;
        end
        else if (++ph == 4)
        begin
            ph = 0;
            bclk <= ~bclk;
            if (bclk)
            begin
                // word pulse one bit clock wide, launched on a falling edge
                bit_n = (bit_n + 1) % 32;
                wclk <= (bit_n == 0);
                din <= 1'($urandom_range(1));
            end
        end
    end
endmodule : acr_host_model

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import acr_pkg::*;
    logic CLK = 0, RSTN = 0, REG_WE = 0, GENERAL_CALL_SEEN = 0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
    logic [1:0] IFC_FORMAT = 2'h0;
    logic CODEC_POWERED = 1, CONVERTER_CLOCK = 0, MODULATOR_CLOCK = 0;
    logic SAMPLE_RATE_CLOCK = 0, MFP = 0, tb_pb = 0, tb_pw = 0, tb_pd = 0;
    logic host_run = 0, h_b, h_w, h_d, b_q = 0, w_q = 0, o_q = 0, armed = 0;
    logic CORE_BCLK, CORE_WCLK, CORE_DIN, PRI_BCLK_OUT, PRI_WCLK_OUT;
    logic SEC_BCLK_OUT, SEC_WCLK_OUT, SLOT_START, GENERAL_CALL_ACK;
    logic [7:0] mdl [8'h1C:8'h24];
    logic [7:0] off_q = 8'h00, a, s, l, r, ic;
    logic [6:0] ev, gv;
    logic [5:0] p;
    int num_errors = 0, compares = 0, cyc = 0, bcnt = 0, slots = 0;
    int orises = 0;
    logic live = 0;
    wire logic pb = host_run ? h_b : tb_pb;
    wire logic pw = host_run ? h_w : tb_pw;
    wire logic pd = host_run ? h_d : tb_pd;

    always #5 CLK = ~CLK;

    acr_host_model HOST (.clk(CLK), .run(host_run), .bclk(h_b),
        .wclk(h_w), .din(h_d));

    acr_audio_port_clock_routing DUT (.CLK(CLK), .RSTN(RSTN),
        .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .IFC_FORMAT(IFC_FORMAT),
        .CODEC_POWERED(CODEC_POWERED), .CONVERTER_CLOCK(CONVERTER_CLOCK),
        .MODULATOR_CLOCK(MODULATOR_CLOCK),
        .SAMPLE_RATE_CLOCK(SAMPLE_RATE_CLOCK), .PRI_BCLK_IN(pb),
        .PRI_WCLK_IN(pw), .PRI_DIN(pd), .MULTIFUNCTION_PIN_IN(MFP),
        .GENERAL_CALL_SEEN(GENERAL_CALL_SEEN), .CORE_BCLK(CORE_BCLK),
        .CORE_WCLK(CORE_WCLK), .CORE_DIN(CORE_DIN),
        .PRI_BCLK_OUT(PRI_BCLK_OUT), .PRI_WCLK_OUT(PRI_WCLK_OUT),
        .SEC_BCLK_OUT(SEC_BCLK_OUT), .SEC_WCLK_OUT(SEC_WCLK_OUT),
        .SLOT_START(SLOT_START), .GENERAL_CALL_ACK(GENERAL_CALL_ACK));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(string what, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h got %h", what, e, g);
        end
    endtask : chk

    function automatic logic [7:0] msk(logic [7:0] ad);
        case (ad)
            ADDR_IFC_TWO: return MASK_IFC_TWO;
            ADDR_SEC_SEL: return MASK_SEC_SEL;
            ADDR_ROUTING: return MASK_ROUTING;
            ADDR_BUS_COND: return MASK_BUS_COND;
            default: return 8'hFF;
        endcase
    endfunction : msk

    // p = {pri bclk, pri wclk, pri din, pin, sample clock, codec power}
    function automatic logic [6:0] route_exp(logic [7:0] sr, sl, rt, ci,
        logic [5:0] pp);
        logic sb, sw, sd, g;
        sb = (sr[7:5] == 3'h0) & pp[2];
        sw = (sr[4:2] == 3'h0) & pp[2];
        sd = (sr[1:0] == 2'h0) & pp[2];
        g = pp[1] & (pp[0] | ci[BIT_KEEP_ALIVE]);
        // divider held off here, so the generated bit clock stands low
        return {sl[3] ? sb : pp[5], sl[2] ? sw : pp[4], sl[0] ? sd : pp[3],
            (rt[7] & sb) ^ ci[3],
            (rt[5:4] == 2'h0) ? g : (rt[5:4] == 2'h2) & sw,
            (~rt[6] & pp[5]) ^ ci[3],
            (rt[3:2] == 2'h0) ? pp[4] : (rt[3:2] == 2'h1) & g};
    endfunction : route_exp

    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(negedge CLK);
        REG_WE = 1'b1;
        REG_ADDR = ad;
        REG_WDATA = d;
        @(negedge CLK);
        REG_WE = 1'b0;
        if (ad >= ADDR_SLOT_OFFSET && ad <= ADDR_BUS_COND)
            mdl[ad] = d & msk(ad);
    endtask : wr

    task automatic rd(logic [7:0] ad, logic [7:0] e);
        @(negedge CLK);
        REG_ADDR = ad;
        @(negedge CLK);
        chk("register read", e, REG_RDATA);
    endtask : rd

    // codec power is restored each case; ratio counted on primary output
    task automatic div_case(logic [7:0] dv, logic [7:0] ci, logic src,
        logic pw_on, int n, int e);
        wr(ADDR_IFC_TWO, ci);
        wr(ADDR_ROUTING, 8'h00);
        wr(ADDR_BIT_DIV, dv);
        CODEC_POWERED = pw_on;
        orises = 0;
        // source kept well below half the system clock
        repeat (n)
        begin
            repeat (2) @(negedge CLK);
            CONVERTER_CLOCK = !src;
            MODULATOR_CLOCK = src;
            repeat (2) @(negedge CLK);
            CONVERTER_CLOCK = 1'b0;
            MODULATOR_CLOCK = 1'b0;
        end
        repeat (4) @(negedge CLK);
        compares++;
        if (orises > e + 1 || orises + 1 < e)
        begin
            num_errors++;
            $display("[FAIL] divider edges expected %0d got %0d", e, orises);
        end
        CODEC_POWERED = 1'b1;
    endtask : div_case

    always @(posedge CLK)
    begin
        if (CORE_WCLK && !w_q)
        begin
            bcnt = 0;
            armed = 1'b1;
        end
        else if (CORE_BCLK && !b_q)
            bcnt++;
        if (PRI_BCLK_OUT && !o_q)
            orises++;
        if (SLOT_START && armed)
            slots++;
        if (SLOT_START && armed && live)
            chk("slot offset", off_q, bcnt[7:0]);
        w_q = CORE_WCLK;
        b_q = CORE_BCLK;
        o_q = PRI_BCLK_OUT;
        if (++cyc == 30000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(23));
        foreach (mdl[i])
            mdl[i] = (i == ADDR_BIT_DIV) ? RST_BIT_DIV : RSVD_READ;
        repeat (10) @(posedge CLK);
        @(negedge CLK);
        RSTN = 1'b1;
        for (int i = 8'h1C; i <= 8'h24; i++)
            rd(8'(i), mdl[i]);
        repeat (60)
        begin
            a = 8'h1C + 8'($urandom_range(6));
            s = (a == ADDR_BUS_COND) ? 8'($urandom) & 8'h20 : 8'($urandom);
            wr(a, s);
            rd(a, mdl[a]);
        end
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        $display("test registers done");
        for (int en = 0; en < 2; en++)
        begin
            wr(ADDR_BUS_COND, en ? 8'h20 : 8'h00);
            GENERAL_CALL_SEEN = 1'b1;
            @(negedge CLK);
            GENERAL_CALL_SEEN = 1'b0;
            chk("general call ack", 8'(en), 8'(GENERAL_CALL_ACK));
            @(negedge CLK);
            chk("ack length", 8'h00, 8'(GENERAL_CALL_ACK));
        end
        $display("test general call done");
        // divider kept off so the generated bit clock is quiet
        wr(ADDR_BIT_DIV, 8'h01);
        repeat (150)
        begin
            s = 8'($urandom);
            l = 8'($urandom) & MASK_SEC_SEL;
            r = 8'($urandom) & MASK_ROUTING;
            ic = 8'($urandom) & MASK_IFC_TWO;
            wr(ADDR_SEC_SRC, s);
            wr(ADDR_SEC_SEL, l);
            wr(ADDR_ROUTING, r);
            wr(ADDR_IFC_TWO, ic);
            repeat (2)
            begin
                p = 6'($urandom);
                {tb_pb, tb_pw, tb_pd, MFP, SAMPLE_RATE_CLOCK, CODEC_POWERED} = p;
                @(negedge CLK);
                ev = route_exp(s, l, r, ic, p);
                gv = {CORE_BCLK, CORE_WCLK, CORE_DIN, PRI_BCLK_OUT,
                    PRI_WCLK_OUT, SEC_BCLK_OUT, SEC_WCLK_OUT};
                chk("core bclk", 8'(ev[6]), 8'(gv[6]));
                chk("core wclk", 8'(ev[5]), 8'(gv[5]));
                chk("core din", 8'(ev[4]), 8'(gv[4]));
                chk("pri bclk", 8'(ev[3]), 8'(gv[3]));
                chk("pri wclk", 8'(ev[2]), 8'(gv[2]));
                chk("sec bclk", 8'(ev[1]), 8'(gv[1]));
                chk("sec wclk", 8'(ev[0]), 8'(gv[0]));
            end
        end
        CODEC_POWERED = 1'b1;
        $display("test routing done");
        div_case(8'h84, 8'h00, 1'b0, 1'b1, 64, 16);
        div_case(8'h80, 8'h00, 1'b0, 1'b1, 256, 2);
        div_case(8'h83, 8'h01, 1'b1, 1'b1, 48, 16);
        div_case(8'h04, 8'h00, 1'b0, 1'b1, 64, 0);
        div_case(8'h84, 8'h00, 1'b0, 1'b0, 64, 0);
        div_case(8'h84, 8'h04, 1'b0, 1'b0, 64, 16);
        div_case(8'h84, 8'h02, 1'b0, 1'b1, 64, 0);
        $display("test divider done");
        wr(ADDR_IFC_TWO, 8'h00);
        wr(ADDR_SEC_SEL, 8'h00);
        IFC_FORMAT = FMT_PULSE;
        host_run = 1'b1;
        foreach (mdl[i])
        begin
            // offsets kept inside one 32-bit frame of the host
            live = 1'b0;
            off_q = (i < 8'h1F) ? 8'(i - 8'h1C) * 8'h03 : 8'($urandom_range(28));
            wr(ADDR_SLOT_OFFSET, off_q);
            // a frame started before the write still runs on the old offset
            @(negedge CLK);
            armed = 1'b0;
            live = 1'b1;
            slots = 0;
            repeat (768) @(negedge CLK);
            chk("slot pulses", 8'h01, 8'(slots >= 2));
        end
        for (int f = 0; f < 4; f++)
        begin
            IFC_FORMAT = 2'(f);
            slots = 0;
            repeat (600) @(negedge CLK);
            chk("slot pulses", 8'(f == 1), 8'(slots > 0));
        end
        $display("test slot offset done");
        end_of_test();
    end
endmodule : testbench

/* File: src/acr_audio_port_clock_routing.sv */
`timescale 1ns/1ns
// Overview of operation
// - slot starts offset bit clocks after word edge
// - invert bit clock, primary and secondary
// - keep clocks running while codec powered down
// - divider source: converter or modulator clock
// - divider power bit, reset clear
// - ratio is field, zero means 128
// - secondary bit clock from multifunction pin
// - secondary word clock from multifunction pin
// - secondary data input from multifunction pin
// - select primary/secondary bit clock for core
// - select primary/secondary word clock for core
// - select primary/secondary data input for core
// - primary bit clock output routing
// - secondary bit clock output routing
// - primary word clock output routing
// - secondary word clock output routing
// - general-call address accepted only when enabled
// - format field selects four interface formats
module acr_audio_port_clock_routing
    import acr_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic REG_WE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic [1:0] IFC_FORMAT,
    input wire logic CODEC_POWERED,
    input wire logic CONVERTER_CLOCK,
    input wire logic MODULATOR_CLOCK,
    input wire logic SAMPLE_RATE_CLOCK,
    input wire logic PRI_BCLK_IN,
    input wire logic PRI_WCLK_IN,
    input wire logic PRI_DIN,
    input wire logic MULTIFUNCTION_PIN_IN,
    input wire logic GENERAL_CALL_SEEN,
    output logic CORE_BCLK,
    output logic CORE_WCLK,
    output logic CORE_DIN,
    output logic PRI_BCLK_OUT,
    output logic PRI_WCLK_OUT,
    output logic SEC_BCLK_OUT,
    output logic SEC_WCLK_OUT,
    output logic SLOT_START,
    output logic GENERAL_CALL_ACK
);
    import acr_pkg::*;

    // --------------------------------------------------------------
    // register file
    // --------------------------------------------------------------
    logic [7:0] slot_offset_q, slot_offset_d;
    logic [7:0] ifc_two_q, ifc_two_d;
    logic [7:0] bit_div_q, bit_div_d;
    logic [7:0] sec_src_q, sec_src_d;
    logic [7:0] sec_sel_q, sec_sel_d;
    logic [7:0] routing_q, routing_d;
    logic [7:0] bus_cond_q, bus_cond_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb
    begin
        slot_offset_d = slot_offset_q;
        ifc_two_d = ifc_two_q;
        bit_div_d = bit_div_q;
        sec_src_d = sec_src_q;
        sec_sel_d = sec_sel_q;
        routing_d = routing_q;
        bus_cond_d = bus_cond_q;
        if (REG_WE)
        begin
            unique case (REG_ADDR)
                ADDR_SLOT_OFFSET: slot_offset_d = REG_WDATA;
                ADDR_IFC_TWO: ifc_two_d = REG_WDATA & MASK_IFC_TWO;
                ADDR_BIT_DIV: bit_div_d = REG_WDATA;
                ADDR_SEC_SRC: sec_src_d = REG_WDATA;
                ADDR_SEC_SEL: sec_sel_d = REG_WDATA & MASK_SEC_SEL;
                ADDR_ROUTING: routing_d = REG_WDATA & MASK_ROUTING;
                // reserved bits held at reset value whatever is written
                ADDR_BUS_COND: bus_cond_d = REG_WDATA & MASK_BUS_COND;
                default: ;
            endcase
        end
        // reserved registers read as zero, writes dropped
        unique case (REG_ADDR)
            ADDR_SLOT_OFFSET: rdata_d = slot_offset_q;
            ADDR_IFC_TWO: rdata_d = ifc_two_q;
            ADDR_BIT_DIV: rdata_d = bit_div_q;
            ADDR_SEC_SRC: rdata_d = sec_src_q;
            ADDR_SEC_SEL: rdata_d = sec_sel_q;
            ADDR_ROUTING: rdata_d = routing_q;
            ADDR_BUS_COND: rdata_d = bus_cond_q;
            default: rdata_d = RSVD_READ;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            slot_offset_q <= RST_SLOT_OFFSET;
            ifc_two_q <= RST_IFC_TWO;
            bit_div_q <= RST_BIT_DIV;
            sec_src_q <= RST_SEC_SRC;
            sec_sel_q <= RST_SEC_SEL;
            routing_q <= RST_ROUTING;
            bus_cond_q <= RST_BUS_COND;
            rdata_q <= RSVD_READ;
        end
        else
        begin
            slot_offset_q <= slot_offset_d;
            ifc_two_q <= ifc_two_d;
            bit_div_q <= bit_div_d;
            sec_src_q <= sec_src_d;
            sec_sel_q <= sec_sel_d;
            routing_q <= routing_d;
            bus_cond_q <= bus_cond_d;
            rdata_q <= rdata_d;
        end
    end

    // --------------------------------------------------------------
    // bit-clock divider
    // --------------------------------------------------------------
    acr_div_if div_bus ();

    always_comb
    begin
        div_bus.enable = bit_div_q[BIT_DIV_POWER];
        div_bus.ratio = bit_div_q[RATIO_W-1:0];
        // reserved source codes give no clock
        unique case (ifc_two_q[1:0])
            SRC_CONV_CLK: div_bus.clk_in = CONVERTER_CLOCK;
            SRC_MOD_CLK: div_bus.clk_in = MODULATOR_CLOCK;
            default: div_bus.clk_in = 1'b0;
        endcase
    end

    acr_bit_divider u_div (
        .clk(CLK),
        .rst_n(RSTN),
        .dv(div_bus)
    );

    // --------------------------------------------------------------
    // secondary sources and clock routing
    // --------------------------------------------------------------
    logic sec_bclk, sec_wclk, sec_din;
    logic gen_bclk, gen_wclk, run_ok;
    logic inv;
    logic core_bclk_d, core_wclk_d, core_din_d;
    logic pb_d, pw_d, sb_d, sw_d;

    always_comb
    begin
        // pin shared by all three; non-selected sources read low
        sec_bclk = (sec_src_q[7:5] == PIN_TAKEN3) & MULTIFUNCTION_PIN_IN;
        sec_wclk = (sec_src_q[4:2] == PIN_TAKEN3) & MULTIFUNCTION_PIN_IN;
        sec_din = (sec_src_q[1:0] == PIN_TAKEN2) & MULTIFUNCTION_PIN_IN;
        inv = ifc_two_q[BIT_INVERT];
        // generated clocks stop with the codec unless kept alive
        run_ok = CODEC_POWERED | ifc_two_q[BIT_KEEP_ALIVE];
        gen_bclk = div_bus.clk_out & run_ok;
        gen_wclk = SAMPLE_RATE_CLOCK & run_ok;
        core_bclk_d = sec_sel_q[BIT_SEL_BCLK] ? sec_bclk : PRI_BCLK_IN;
        core_wclk_d = sec_sel_q[BIT_SEL_WCLK] ? sec_wclk : PRI_WCLK_IN;
        core_din_d = sec_sel_q[BIT_SEL_DIN] ? sec_din : PRI_DIN;
        pb_d = inv ^ (routing_q[BIT_PRI_BCLK_ROUTE] ? sec_bclk
            : gen_bclk);
        sb_d = inv ^ (routing_q[BIT_SEC_BCLK_ROUTE] ? gen_bclk
            : PRI_BCLK_IN);
        unique case (routing_q[5:4])
            PWCLK_INTERNAL: pw_d = gen_wclk;
            PWCLK_SECONDARY: pw_d = sec_wclk;
            default: pw_d = 1'b0;
        endcase
        unique case (routing_q[3:2])
            SWCLK_PRIMARY: sw_d = PRI_WCLK_IN;
            SWCLK_INTERNAL: sw_d = gen_wclk;
            default: sw_d = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // slot offset counter, pulse-synchronised format only
    // --------------------------------------------------------------
    logic wclk_q, bclk_q;
    logic [8:0] slot_cnt_q, slot_cnt_d;
    logic slot_q, slot_d;
    logic gc_q, gc_d;

    always_comb
    begin
        slot_cnt_d = slot_cnt_q;
        slot_d = 1'b0;
        if (IFC_FORMAT != FMT_PULSE)
            slot_cnt_d = 9'h100;
        else if (core_wclk_d & ~wclk_q)
        begin
            slot_cnt_d = {1'b0, slot_offset_q};
            slot_d = (slot_offset_q == 8'h00);
            if (slot_d)
                slot_cnt_d = 9'h100;
        end
        else if (~slot_cnt_q[8] & core_bclk_d & ~bclk_q)
        begin
            slot_cnt_d = slot_cnt_q - 9'h001;
            if (slot_cnt_q == 9'h001)
            begin
                slot_d = 1'b1;
                slot_cnt_d = 9'h100;
            end
        end
        gc_d = GENERAL_CALL_SEEN & bus_cond_q[BIT_GENERAL_CALL];
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wclk_q <= 1'b0;
            bclk_q <= 1'b0;
            slot_cnt_q <= 9'h100;
            slot_q <= 1'b0;
            gc_q <= 1'b0;
            CORE_BCLK <= 1'b0;
            CORE_WCLK <= 1'b0;
            CORE_DIN <= 1'b0;
            PRI_BCLK_OUT <= 1'b0;
            PRI_WCLK_OUT <= 1'b0;
            SEC_BCLK_OUT <= 1'b0;
            SEC_WCLK_OUT <= 1'b0;
        end
        else
        begin
            wclk_q <= core_wclk_d;
            bclk_q <= core_bclk_d;
            slot_cnt_q <= slot_cnt_d;
            slot_q <= slot_d;
            gc_q <= gc_d;
            CORE_BCLK <= core_bclk_d;
            CORE_WCLK <= core_wclk_d;
            CORE_DIN <= core_din_d;
            PRI_BCLK_OUT <= pb_d;
            PRI_WCLK_OUT <= pw_d;
            SEC_BCLK_OUT <= sb_d;
            SEC_WCLK_OUT <= sw_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign SLOT_START = slot_q;
    assign GENERAL_CALL_ACK = gc_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_gc_ignored: assert property (@(posedge CLK) disable iff (!RSTN)
        !bus_cond_q[BIT_GENERAL_CALL] |=> !GENERAL_CALL_ACK)
        else $error("general call answered while disabled");
    a_gc_answered: assert property (@(posedge CLK) disable iff (!RSTN)
        bus_cond_q[BIT_GENERAL_CALL] && GENERAL_CALL_SEEN |=> GENERAL_CALL_ACK)
        else $error("general call not answered");
    a_core_din_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        !sec_sel_q[BIT_SEL_DIN] |=> CORE_DIN == $past(PRI_DIN))
        else $error("primary data not routed");
    a_core_wclk_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        sec_sel_q[BIT_SEL_WCLK] && sec_src_q[4:2] == PIN_TAKEN3
        |=> CORE_WCLK == $past(MULTIFUNCTION_PIN_IN))
        else $error("secondary word clock not routed");
    a_core_bclk_sel: assert property (@(posedge CLK) disable iff (!RSTN)
        sec_sel_q[BIT_SEL_BCLK] && sec_src_q[7:5] != PIN_TAKEN3
        |=> !CORE_BCLK) else $error("bit clock taken from pin");
    a_sec_bclk_inv: assert property (@(posedge CLK) disable iff (!RSTN)
        !routing_q[BIT_SEC_BCLK_ROUTE]
        |=> SEC_BCLK_OUT == ($past(PRI_BCLK_IN) ^ $past(inv)))
        else $error("secondary bit clock wrong");
    a_gen_stops_off: assert property (@(posedge CLK) disable iff (!RSTN)
        !CODEC_POWERED && !ifc_two_q[BIT_KEEP_ALIVE]
        && routing_q[5:4] == PWCLK_INTERNAL |=> !PRI_WCLK_OUT)
        else $error("word clock runs while powered down");
    a_sec_wclk_route: assert property (@(posedge CLK) disable iff (!RSTN)
        routing_q[3:2] == SWCLK_PRIMARY |=> SEC_WCLK_OUT == $past(PRI_WCLK_IN))
        else $error("secondary word clock wrong");
    a_slot_only_pulse: assert property (@(posedge CLK) disable iff (!RSTN)
        IFC_FORMAT != FMT_PULSE |=> !SLOT_START)
        else $error("slot start outside pulse format");
    a_pri_bclk_off: assert property (@(posedge CLK) disable iff (!RSTN)
        !bit_div_q[BIT_DIV_POWER] ##1 !bit_div_q[BIT_DIV_POWER]
        && !routing_q[BIT_PRI_BCLK_ROUTE] |=> PRI_BCLK_OUT == $past(inv))
        else $error("bit clock edges with divider off");
endmodule : acr_audio_port_clock_routing

/* File: src/acr_bit_divider.sv */
`timescale 1ns/1ns
module acr_bit_divider
    import acr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    acr_div_if.div dv
);
    logic in_q;
    logic in_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic out_q;
    logic out_d;
    logic [7:0] ratio;
    logic rise;

    // --------------------------------------------------------------
    // divider on rising edges of the sampled source
    // --------------------------------------------------------------
    always_comb
    begin
        ratio = (dv.ratio == 7'h00) ? RATIO_ZERO_MEANS : {1'b0, dv.ratio};
        rise = dv.clk_in & ~in_q;
        in_d = dv.clk_in;
        cnt_d = cnt_q;
        out_d = out_q;
        if (!dv.enable)
        begin
            // powered down: no edges at all
            cnt_d = 8'h00;
            out_d = 1'b0;
        end
        else if (rise)
        begin
            // one output period per ratio source periods, or per two source periods when ratio is 1
            if (cnt_q + 8'h01 >= ratio)
                cnt_d = 8'h00;
            else
                cnt_d = cnt_q + 8'h01;
            out_d = (cnt_d < {1'b0, ratio[7:1]}) || (ratio == 8'h01 ? ~out_q
                : 1'b0);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_q <= 1'b0;
            cnt_q <= 8'h00;
            out_q <= 1'b0;
        end
        else
        begin
            in_q <= in_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign dv.clk_out = out_q;

    a_div_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !dv.enable |=> !out_q) else $error("divider toggled while off");
endmodule : acr_bit_divider

/* File: src/acr_div_if.sv */
`timescale 1ns/1ns
interface acr_div_if;
    logic enable;
    logic [6:0] ratio;
    logic clk_in;
    logic clk_out;
    modport ctrl (output enable, output ratio, output clk_in, input clk_out);
    modport div (input enable, input ratio, input clk_in, output clk_out);
endinterface : acr_div_if

/* File: src/acr_pkg.sv */
package acr_pkg;
    // --------------------------------------------------------------
    // register indices
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_SLOT_OFFSET = 8'h1C;
    localparam logic [7:0] ADDR_IFC_TWO = 8'h1D;
    localparam logic [7:0] ADDR_BIT_DIV = 8'h1E;
    localparam logic [7:0] ADDR_SEC_SRC = 8'h1F;
    localparam logic [7:0] ADDR_SEC_SEL = 8'h20;
    localparam logic [7:0] ADDR_ROUTING = 8'h21;
    localparam logic [7:0] ADDR_BUS_COND = 8'h22;
    localparam logic [7:0] ADDR_RSVD_A = 8'h23;
    localparam logic [7:0] ADDR_RSVD_B = 8'h24;
    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_SLOT_OFFSET = 8'h00;
    localparam logic [7:0] RST_IFC_TWO = 8'h00;
    localparam logic [7:0] RST_BIT_DIV = 8'h01;
    localparam logic [7:0] RST_SEC_SRC = 8'h00;
    localparam logic [7:0] RST_SEC_SEL = 8'h00;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam logic [7:0] RST_BUS_COND = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int BIT_INVERT = 3;
    localparam int BIT_KEEP_ALIVE = 2;
    localparam int BIT_DIV_POWER = 7;
    localparam int BIT_SEL_BCLK = 3;
    localparam int BIT_SEL_WCLK = 2;
    localparam int BIT_SEL_DIN = 0;
    localparam int BIT_PRI_BCLK_ROUTE = 7;
    localparam int BIT_SEC_BCLK_ROUTE = 6;
    localparam int BIT_GENERAL_CALL = 5;
    localparam logic [7:0] MASK_IFC_TWO = 8'h0F;
    localparam logic [7:0] MASK_SEC_SEL = 8'h0D;
    localparam logic [7:0] MASK_ROUTING = 8'hFC;
    localparam logic [7:0] MASK_BUS_COND = 8'h20;
    // --------------------------------------------------------------
    // codes
    // --------------------------------------------------------------
    localparam logic [1:0] FMT_PULSE = 2'h1;
    localparam logic [1:0] SRC_CONV_CLK = 2'h0;
    localparam logic [1:0] SRC_MOD_CLK = 2'h1;
    localparam logic [2:0] PIN_TAKEN3 = 3'h0;
    localparam logic [1:0] PIN_TAKEN2 = 2'h0;
    localparam logic [1:0] PWCLK_INTERNAL = 2'h0;
    localparam logic [1:0] PWCLK_SECONDARY = 2'h2;
    localparam logic [1:0] SWCLK_PRIMARY = 2'h0;
    localparam logic [1:0] SWCLK_INTERNAL = 2'h1;
    localparam logic [7:0] RATIO_ZERO_MEANS = 8'h80;
    localparam int RATIO_W = 7;
endpackage : acr_pkg
